// File: core/pwm_reload_pkg.sv
/*
  Shared constants for the PWM reload, flag and control block: register
  offsets, bit positions, reset values, mode and counter state types.
  Assumes an 8-bit register port with a 4-bit word address.
*/
package pwm_reload_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int VAL_W = 16;
  localparam int NUM_SLOTS = 4;
  localparam int NUM_FLAGS = 4;

  // Register offsets
  localparam logic [3:0] OFS_WAVE_CTRL = 4'h0;
  localparam logic [3:0] OFS_RELOAD_CTRL = 4'h1;
  localparam logic [3:0] OFS_VALUE_FIRST = 4'h2;
  localparam logic [3:0] OFS_VALUE_LAST = 4'h9;
  localparam logic [3:0] OFS_OFFSET_CTRL = 4'hA;
  localparam logic [3:0] OFS_MATCH_FLAGS = 4'hB;
  localparam logic [3:0] OFS_CLOCK_SEL = 4'hC;

  // Value slots inside the double buffer
  localparam logic [1:0] SLOT_PHASE = 2'h0;
  localparam logic [1:0] SLOT_DUTY = 2'h1;
  localparam logic [1:0] SLOT_PERIOD = 2'h2;
  localparam logic [1:0] SLOT_OFFSET = 2'h3;

  // Field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_OUT_BIT = 5;
  localparam int CTRL_POL_BIT = 4;
  localparam int CTRL_MODE_LSB = 2;
  localparam int LD_ARM_BIT = 7;
  localparam int LD_METHOD_BIT = 6;
  localparam int LD_SOURCE_BIT = 0;
  localparam int OFS_DIR_BIT = 0;
  localparam int FLAG_PERIOD = 0;
  localparam int FLAG_DUTY = 1;
  localparam int FLAG_PHASE = 2;
  localparam int FLAG_OFFSET = 3;

  // Values after reset
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] CLOCK_SEL_RESET = 2'h0;

  // Clock source codes that keep running in sleep
  localparam logic [1:0] CLK_FAST_INTERNAL_OSC = 2'h1;
  localparam logic [1:0] CLK_SLOW_INTERNAL_OSC = 2'h2;

  typedef enum logic [1:0] {
    MODE_STANDARD = 2'h0,
    MODE_SET_ON_MATCH = 2'h1,
    MODE_TOGGLE = 2'h2,
    MODE_CENTER = 2'h3
  } wave_mode_t;

  typedef enum logic [2:0] {
    CNT_IDLE = 3'b001,
    CNT_UP = 3'b010,
    CNT_DOWN = 3'b100
  } count_state_t;

  // Value slot addressed by a register offset; index 0 is phase low
  function automatic logic [1:0] value_slot(input logic [3:0] addr);
    logic [3:0] rel;
    rel = addr - OFS_VALUE_FIRST;
    return rel[2:1];
  endfunction

  function automatic logic is_value_addr(input logic [3:0] addr);
    return (addr >= OFS_VALUE_FIRST) && (addr <= OFS_VALUE_LAST);
  endfunction

endpackage

// File: core/pwm_core_if.sv
/*
  Internal carrier between the control top, the double buffer and the
  match flag block. Assumes all three share clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
interface pwm_core_if;
  import pwm_reload_pkg::*;

  logic wr_en;
  logic [1:0] wr_slot;
  logic wr_hi;
  logic [7:0] wr_data;
  logic dir_wr;
  logic dir_data;
  logic load;
  logic [NUM_SLOTS-1:0][VAL_W-1:0] shadow_val;
  logic [NUM_SLOTS-1:0][VAL_W-1:0] oper_val;
  logic shadow_dir;
  logic oper_dir;
  logic en;
  logic [NUM_FLAGS-1:0] match;
  logic flag_wr;
  logic [NUM_FLAGS-1:0] flag_wdata;
  logic [NUM_FLAGS-1:0] flags;

  modport buffer (
    input wr_en, wr_slot, wr_hi, wr_data, dir_wr, dir_data, load,
    output shadow_val, oper_val, shadow_dir, oper_dir
  );

  modport flag_side (
    input en, match, flag_wr, flag_wdata,
    output flags
  );

  modport ctrl (
    output wr_en, wr_slot, wr_hi, wr_data, dir_wr, dir_data, load,
    output en, match, flag_wr, flag_wdata,
    input shadow_val, oper_val, shadow_dir, oper_dir, flags
  );
endinterface
`default_nettype wire

// File: core/pwm_double_buffer.sv
/*
  Shadow and operating copies of phase, duty, period, offset and the
  offset direction bit. Assumes load is a one-cycle pulse from the top.
*/
`timescale 1ns/10ps
`default_nettype none
module pwm_double_buffer
  import pwm_reload_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Control side
  pwm_core_if.buffer bus
);

  logic [NUM_SLOTS-1:0][VAL_W-1:0] shadow_reg, shadow_next;
  logic [NUM_SLOTS-1:0][VAL_W-1:0] oper_reg, oper_next;
  logic shadow_dir_reg, shadow_dir_next;
  logic oper_dir_reg, oper_dir_next;

  // Software only ever touches the shadow side
  always_comb begin
    shadow_next = shadow_reg;
    shadow_dir_next = shadow_dir_reg;
    if (bus.wr_en) begin
      if (bus.wr_hi) begin
        shadow_next[bus.wr_slot][15:8] = bus.wr_data;
      end else begin
        shadow_next[bus.wr_slot][7:0] = bus.wr_data;
      end
    end
    if (bus.dir_wr) begin
      shadow_dir_next = bus.dir_data;
    end
  end

  // All pairs move together; old shadow wins over a same-cycle write
  always_comb begin
    oper_next = oper_reg;
    oper_dir_next = oper_dir_reg;
    if (bus.load) begin
      oper_next = shadow_reg;
      oper_dir_next = shadow_dir_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      shadow_reg <= '0;
      oper_reg <= '0;
      shadow_dir_reg <= 1'b0;
      oper_dir_reg <= 1'b0;
    end else begin
      shadow_reg <= shadow_next;
      oper_reg <= oper_next;
      shadow_dir_reg <= shadow_dir_next;
      oper_dir_reg <= oper_dir_next;
    end
  end

  assign bus.shadow_val = shadow_reg;
  assign bus.oper_val = oper_reg;
  assign bus.shadow_dir = shadow_dir_reg;
  assign bus.oper_dir = oper_dir_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_load_copies;
    bus.load |=> (oper_reg == $past(shadow_reg)) && (oper_dir_reg == $past(shadow_dir_reg));
  endproperty
  a_load_copies: assert property (p_load_copies) else $error("load did not copy shadow");

  property p_operating_hold;
    !bus.load |=> $stable(oper_reg) && $stable(oper_dir_reg);
  endproperty
  a_operating_hold: assert property (p_operating_hold) else $error("operating copy moved");

endmodule
`default_nettype wire

// File: core/pwm_match_flags.sv
/*
  Four match interrupt flags, set on the rising edge of each match
  signal. Assumes match lines are on clk_sys and glitch free.
*/
`timescale 1ns/10ps
`default_nettype none
module pwm_match_flags
  import pwm_reload_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Control side
  pwm_core_if.flag_side bus
);

  logic [NUM_FLAGS-1:0] match_prev_reg, match_prev_next;
  logic [NUM_FLAGS-1:0] flag_reg, flag_next;
  logic [NUM_FLAGS-1:0] rise;

  // Edge set beats a software clear in the same cycle
  always_comb begin
    rise = bus.match & ~match_prev_reg;
    match_prev_next = bus.match;
    flag_next = (bus.flag_wr ? bus.flag_wdata : flag_reg) | rise;
    if (!bus.en) begin
      flag_next = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      match_prev_reg <= '0;
      flag_reg <= '0;
    end else begin
      match_prev_reg <= match_prev_next;
      flag_reg <= flag_next;
    end
  end

  assign bus.flags = flag_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_flag_on_rise;
    bus.en && bus.match[FLAG_PERIOD] && !match_prev_reg[FLAG_PERIOD] |=> flag_reg[FLAG_PERIOD];
  endproperty
  a_flag_on_rise: assert property (p_flag_on_rise) else $error("flag missed an edge");

  property p_flag_level_no_set;
    bus.en && !bus.flag_wr && !(bus.match[FLAG_DUTY] && !match_prev_reg[FLAG_DUTY])
      |=> flag_reg[FLAG_DUTY] == $past(flag_reg[FLAG_DUTY]);
  endproperty
  a_flag_level_no_set: assert property (p_flag_level_no_set) else $error("flag set by level");

  property p_flags_off;
    !bus.en |=> flag_reg == '0;
  endproperty
  a_flags_off: assert property (p_flags_off) else $error("flags not held clear");

endmodule
`default_nettype wire

// File: core/pwm_reload_ctrl.sv
/*
  PWM control top: register port, waveform counter, match detection,
  output waveform and the armed double-buffer reload. Assumes the sibling
  load events and sleep indication are produced on clk_sys.
*/
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Shadow copies kept apart from operating copies
// - Writes change only shadow until reload
// - Reload needs load arm set
// - All four pairs transfer in one cycle
// - Immediate mode loads at next period event
// - Triggered mode waits for sibling load event
// - Trigger source bit picks the sibling
// - Triggered load at period after trigger
// - Completed transfer clears load arm
// - Arm on period match cycle is deferred
// - Runs in sleep on internal oscillators
// - Four match flags per module
// - Flags set on rising match edge
// - Bits 3-2 select waveform mode
// - Counter runs while enable is set
// - Period match is period event, resets counter except when centred with a nonzero period, where it turns the count down
// - Flags held clear while disabled
module pwm_reload_ctrl
  import pwm_reload_pkg::*;
#(
  parameter int NUM_TRIG = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Sibling load events and system state
  input wire logic [NUM_TRIG-1:0] sibling_load,
  input wire logic sleep_mode,
  // Waveform and events
  output logic wave_out,
  output logic load_event,
  output logic [NUM_FLAGS-1:0] match_flags
);

  pwm_core_if core_bus ();

  pwm_double_buffer u_buffer (
    .clk_sys(clk_sys),
    .srst(srst),
    .bus(core_bus)
  );

  pwm_match_flags u_flags (
    .clk_sys(clk_sys),
    .srst(srst),
    .bus(core_bus)
  );

  // Control register fields
  logic en_reg, en_next;
  logic pol_reg, pol_next;
  wave_mode_t mode_reg, mode_next;
  logic lda_reg, lda_next;
  logic ldt_reg, ldt_next;
  logic lds_reg, lds_next;
  logic [1:0] clk_sel_reg, clk_sel_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  // Reload arming
  logic trig_seen_reg, trig_seen_next;
  logic armed_reg, armed_next;
  logic trig_now;
  logic load;
  // Counter and waveform
  count_state_t cnt_state_reg, cnt_state_next;
  logic [VAL_W-1:0] cnt_reg, cnt_next;
  logic out_reg, out_next;
  logic wave_reg, wave_next;
  logic running;
  logic period_event;
  logic phase_m, duty_m, offset_m;
  logic [VAL_W-1:0] up_match, down_match;
  logic wr_ctrl, wr_ld;
  logic [VAL_W-1:0] phase_v, duty_v, period_v, offset_v;

  assign phase_v = core_bus.oper_val[SLOT_PHASE];
  assign duty_v = core_bus.oper_val[SLOT_DUTY];
  assign period_v = core_bus.oper_val[SLOT_PERIOD];
  assign offset_v = core_bus.oper_val[SLOT_OFFSET];
  assign wr_ctrl = reg_wr && (reg_addr == OFS_WAVE_CTRL);
  assign wr_ld = reg_wr && (reg_addr == OFS_RELOAD_CTRL);

  // Register writes into the buffer and flag blocks
  always_comb begin
    core_bus.wr_en = reg_wr && is_value_addr(reg_addr);
    core_bus.wr_slot = value_slot(reg_addr);
    core_bus.wr_hi = reg_addr[0] ^ OFS_VALUE_FIRST[0];
    core_bus.wr_data = reg_wdata;
    core_bus.dir_wr = reg_wr && (reg_addr == OFS_OFFSET_CTRL);
    core_bus.dir_data = reg_wdata[OFS_DIR_BIT];
    core_bus.flag_wr = reg_wr && (reg_addr == OFS_MATCH_FLAGS);
    core_bus.flag_wdata = reg_wdata[NUM_FLAGS-1:0];
    core_bus.en = en_reg;
    core_bus.load = load;
  end

  // Control fields; a hardware clear of the arm loses to a software set
  always_comb begin
    en_next = en_reg;
    pol_next = pol_reg;
    mode_next = mode_reg;
    ldt_next = ldt_reg;
    lds_next = lds_reg;
    clk_sel_next = clk_sel_reg;
    lda_next = load ? 1'b0 : lda_reg;
    if (wr_ctrl) begin
      en_next = reg_wdata[CTRL_EN_BIT];
      pol_next = reg_wdata[CTRL_POL_BIT];
      mode_next = wave_mode_t'(reg_wdata[CTRL_MODE_LSB +: 2]);
    end
    if (wr_ld) begin
      lda_next = reg_wdata[LD_ARM_BIT];
      ldt_next = reg_wdata[LD_METHOD_BIT];
      lds_next = reg_wdata[LD_SOURCE_BIT];
    end
    if (reg_wr && (reg_addr == OFS_CLOCK_SEL)) begin
      clk_sel_next = reg_wdata[1:0];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_comb begin
    rdata_next = BYTE_RESET;
    if (reg_rd) begin
      if (is_value_addr(reg_addr)) begin
        rdata_next = (reg_addr[0] ^ OFS_VALUE_FIRST[0]) ?
          core_bus.shadow_val[value_slot(reg_addr)][15:8] :
          core_bus.shadow_val[value_slot(reg_addr)][7:0];
      end else begin
        case (reg_addr)
          OFS_WAVE_CTRL: begin
            rdata_next = {en_reg, 1'b0, out_reg, pol_reg, mode_reg, 2'b00};
          end
          OFS_RELOAD_CTRL: begin
            rdata_next = {lda_reg, ldt_reg, 5'h00, lds_reg};
          end
          OFS_OFFSET_CTRL: begin
            rdata_next = {7'h00, core_bus.shadow_dir};
          end
          OFS_MATCH_FLAGS: begin
            rdata_next = {4'h0, core_bus.flags};
          end
          OFS_CLOCK_SEL: begin
            rdata_next = {6'h00, clk_sel_reg};
          end
          default: begin
            rdata_next = BYTE_RESET;
          end
        endcase
      end
    end
  end

  // Counter keeps going in sleep only on the internal oscillators
  always_comb begin
    running = en_reg && (!sleep_mode || (clk_sel_reg == CLK_FAST_INTERNAL_OSC) ||
      (clk_sel_reg == CLK_SLOW_INTERNAL_OSC));
    period_event = running && (cnt_state_reg == CNT_UP) && (cnt_reg == period_v);
  end

  // Waveform counter: up with period reset, or up and down when centred
  always_comb begin
    cnt_state_next = cnt_state_reg;
    cnt_next = cnt_reg;
    if (!en_reg) begin
      cnt_state_next = CNT_IDLE;
      cnt_next = VALUE_RESET;
    end else if (running) begin
      case (cnt_state_reg)
        CNT_IDLE: begin
          cnt_state_next = CNT_UP;
        end
        CNT_UP: begin
          if (cnt_reg == period_v) begin
            if (mode_reg == MODE_CENTER && period_v != VALUE_RESET) begin
              cnt_state_next = CNT_DOWN;
              cnt_next = cnt_reg - 16'h0001;
            end else begin
              cnt_next = VALUE_RESET;
            end
          end else begin
            cnt_next = cnt_reg + 16'h0001;
          end
        end
        CNT_DOWN: begin
          if (cnt_reg == VALUE_RESET) begin
            cnt_state_next = CNT_UP;
            cnt_next = 16'h0001;
          end else begin
            cnt_next = cnt_reg - 16'h0001;
          end
        end
        default: begin
          cnt_state_next = CNT_IDLE;
          cnt_next = VALUE_RESET;
        end
      endcase
    end
  end

  // Match detection while the counter is live
  always_comb begin
    phase_m = running && (cnt_state_reg != CNT_IDLE) && (cnt_reg == phase_v);
    duty_m = running && (cnt_state_reg != CNT_IDLE) && (cnt_reg == duty_v);
    offset_m = running && (cnt_state_reg != CNT_IDLE) && (cnt_reg == offset_v);
    // Direction only matters when centred, as the down leg repeats values
    if (mode_reg == MODE_CENTER) begin
      offset_m = offset_m && ((cnt_state_reg == CNT_DOWN) == core_bus.oper_dir);
    end
    core_bus.match = '0;
    core_bus.match[FLAG_PERIOD] = period_event;
    core_bus.match[FLAG_DUTY] = duty_m;
    core_bus.match[FLAG_PHASE] = phase_m;
    core_bus.match[FLAG_OFFSET] = offset_m;
    up_match = period_v - duty_v;
    down_match = up_match + 16'h0001;
  end

  // Output state per mode; polarity applied only at the pin
  always_comb begin
    out_next = out_reg;
    if (!en_reg) begin
      out_next = 1'b0;
    end else begin
      case (mode_reg)
        MODE_STANDARD: begin
          if (duty_m) begin
            out_next = 1'b0;
          end else if (phase_m) begin
            out_next = 1'b1;
          end
        end
        MODE_SET_ON_MATCH: begin
          if (phase_m) begin
            out_next = 1'b1;
          end
        end
        MODE_TOGGLE: begin
          if (phase_m) begin
            out_next = !out_reg;
          end
        end
        MODE_CENTER: begin
          if (running && cnt_state_reg == CNT_UP && cnt_reg == up_match && duty_v != 16'h0000) begin
            out_next = 1'b1;
          end else if (running && cnt_state_reg == CNT_DOWN && cnt_reg == down_match) begin
            out_next = 1'b0;
          end
        end
        default: begin
          out_next = 1'b0;
        end
      endcase
    end
    wave_next = out_next ^ pol_next;
  end

  // Reload arming; an arm seen on the period cycle waits one more event
  always_comb begin
    trig_now = sibling_load[lds_reg];
    trig_seen_next = trig_seen_reg;
    if (!lda_reg || load) begin
      trig_seen_next = 1'b0;
    end else if (trig_now) begin
      trig_seen_next = 1'b1;
    end
    armed_next = lda_reg && !load && (!ldt_reg || trig_now || trig_seen_reg);
    load = armed_reg && lda_reg && period_event;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      en_reg <= 1'b0;
      pol_reg <= 1'b0;
      mode_reg <= MODE_STANDARD;
      lda_reg <= 1'b0;
      ldt_reg <= 1'b0;
      lds_reg <= 1'b0;
      clk_sel_reg <= CLOCK_SEL_RESET;
      rdata_reg <= BYTE_RESET;
      trig_seen_reg <= 1'b0;
      armed_reg <= 1'b0;
      cnt_state_reg <= CNT_IDLE;
      cnt_reg <= VALUE_RESET;
      out_reg <= 1'b0;
      wave_reg <= 1'b0;
    end else begin
      en_reg <= en_next;
      pol_reg <= pol_next;
      mode_reg <= mode_next;
      lda_reg <= lda_next;
      ldt_reg <= ldt_next;
      lds_reg <= lds_next;
      clk_sel_reg <= clk_sel_next;
      rdata_reg <= rdata_next;
      trig_seen_reg <= trig_seen_next;
      armed_reg <= armed_next;
      cnt_state_reg <= cnt_state_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
      wave_reg <= wave_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign wave_out = wave_reg;
  assign load_event = load;
  assign match_flags = core_bus.flags;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_arm_on_period;
    $rose(lda_reg) && period_event;
  endsequence

  property p_load_needs_arm;
    load |-> lda_reg && armed_reg;
  endproperty
  a_load_needs_arm: assert property (p_load_needs_arm) else $error("load without arm");

  property p_load_on_period;
    load |-> period_event;
  endproperty
  a_load_on_period: assert property (p_load_on_period) else $error("load off period event");

  property p_arm_clears;
    load && !wr_ld |=> !lda_reg;
  endproperty
  a_arm_clears: assert property (p_arm_clears) else $error("arm not cleared");

  property p_arm_deferred;
    s_arm_on_period |-> !load;
  endproperty
  a_arm_deferred: assert property (p_arm_deferred) else $error("arm on period not deferred");

  property p_trigger_needed;
    load && ldt_reg |-> trig_seen_reg;
  endproperty
  a_trigger_needed: assert property (p_trigger_needed) else $error("triggered load early");

  property p_immediate_loads;
    lda_reg && !ldt_reg && armed_reg && period_event |-> load ##1 !load;
  endproperty
  a_immediate_loads: assert property (p_immediate_loads) else $error("immediate load missed");

  property p_period_resets;
    period_event && mode_reg != MODE_CENTER |=> cnt_reg == 16'h0000;
  endproperty
  a_period_resets: assert property (p_period_resets) else $error("period did not reset");

  property p_disabled_idle;
    !en_reg |=> cnt_reg == 16'h0000 && cnt_state_reg == CNT_IDLE;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("counter ran disabled");

  property p_sleep_runs;
    en_reg && sleep_mode && clk_sel_reg == CLK_FAST_INTERNAL_OSC && cnt_state_reg == CNT_UP &&
      cnt_reg != period_v && !wr_ctrl |=> cnt_reg == $past(cnt_reg) + 16'h0001;
  endproperty
  a_sleep_runs: assert property (p_sleep_runs) else $error("counter stopped in sleep");

  property p_pin_polarity;
    1'b1 |=> wave_reg == (out_reg ^ pol_reg);
  endproperty
  a_pin_polarity: assert property (p_pin_polarity) else $error("pin polarity wrong");

endmodule
`default_nettype wire

// File: test/sibling_pwm_model.sv
/*
  Sibling PWM model: sends one buffer-load pulse on a chosen line.
  Assumes it shares clk_sys and srst with the block.
*/
`timescale 1ns/10ps
`default_nettype none
module sibling_pwm_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Requests from the bench
  input wire logic fire,
  input wire logic fire_sel,
  input wire logic [3:0] lag,
  // Load events toward the block
  output logic [1:0] sibling_load
);
  logic [4:0] cnt_reg;
  logic sel_reg;
  // Prompt or late pulse, one cycle wide, as a real load event is
  always_ff @(posedge clk_sys) begin
    sibling_load <= 2'h0;
    if (srst) begin
      cnt_reg <= 5'h00;
    end else if (fire) begin
      cnt_reg <= {1'b1, lag};
      sel_reg <= fire_sel;
    end else if (cnt_reg[4]) begin
      if (cnt_reg[3:0] == 4'h0) begin
        sibling_load[sel_reg] <= 1'b1;
        cnt_reg <= 5'h00;
      end else begin
        cnt_reg <= cnt_reg - 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/testbench.sv
/*
  Self-checking bench for pwm_reload_ctrl with a sibling load model.
  Assumes a 4 ns clk_sys and the register map of the package.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pwm_reload_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_mode = 1'b0;
  logic fire = 1'b0;
  logic fire_sel = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [7:0] reg_rdata;
  logic [1:0] sibling_load;
  logic wave_out;
  logic load_event;
  logic [3:0] match_flags;
  int err_total = 0;
  int samples_checked = 0;
  int n;

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  pwm_reload_ctrl #(.NUM_TRIG(2)) pwm_reload_ctrl_inst (.clk_sys(clk_sys), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sibling_load(sibling_load), .sleep_mode(sleep_mode),
    .wave_out(wave_out), .load_event(load_event), .match_flags(match_flags));
  sibling_pwm_model sibling_pwm_model_inst (.clk_sys(clk_sys), .srst(srst), .fire(fire),
    .fire_sel(fire_sel), .lag(lag), .sibling_load(sibling_load));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Bus cycles: one-cycle strobes, read data in the next cycle only
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
  endtask

  // Bounded wait: sel 0 load_event, sel 1 period flag; cnt 0 if never seen
  task automatic wait_sig(input bit sel, input int max, input bit must, output int cnt);
    cnt = 0;
    for (int i = 1; i <= max && cnt == 0; i++) begin
      @(posedge clk_sys);
      #1;
      if ((sel ? match_flags[FLAG_PERIOD] : load_event) === 1'b1) cnt = i;
    end
    if (must && cnt == 0) begin
      err_total++;
      $display("BAD wait expected event seen none");
      close_out();
    end
  endtask

  // Cycles between two period flags; the clear write costs two of them.
  // A stale flag is cleared first so the first wait sees a fresh edge.
  task automatic period_len(input int exp);
    #1;
    for (int i = 0; i < 4 && match_flags[FLAG_PERIOD] !== 1'b0; i++) begin
      wr(OFS_MATCH_FLAGS, 8'h00);
      #1;
    end
    wait_sig(1, 40, 1, n);
    wr(OFS_MATCH_FLAGS, 8'h00);
    wait_sig(1, 40, 1, n);
    chk("period_len", 16'(n + 2), 16'(exp));
  endtask

  task automatic trig(input logic s, input logic [3:0] l);
    @(posedge clk_sys);
    fire <= 1'b1;
    fire_sel <= s;
    lag <= l;
    @(posedge clk_sys);
    fire <= 1'b0;
  endtask

  task automatic t_ctrl();
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), BYTE_RESET);
    end
    wr(OFS_WAVE_CTRL, 8'h7F);
    rd(OFS_WAVE_CTRL, 8'h1C);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_WAVE_CTRL, 8'(m << CTRL_MODE_LSB));
      rd(OFS_WAVE_CTRL, 8'(m << CTRL_MODE_LSB));
    end
    wr(OFS_WAVE_CTRL, 8'h10);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("wave_out", wave_out, 16'h0001);
    wr(OFS_MATCH_FLAGS, 8'h0F);
    rd(OFS_MATCH_FLAGS, 8'h00);
    wr(4'hE, 8'hFF);
    rd(4'hE, 8'h00);
    $display("test ctrl done");
  endtask

  task automatic t_immediate();
    wr(4'h6, 8'h03);
    wr(OFS_RELOAD_CTRL, 8'h80);
    wr(OFS_WAVE_CTRL, 8'h80);
    wait_sig(0, 20, 1, n);
    rd(OFS_RELOAD_CTRL, 8'h00);
    period_len(4);
    wr(4'h6, 8'h05);
    rd(4'h6, 8'h05);
    wait_sig(0, 20, 0, n);
    chk("load_event", 16'(n), 16'h0000);
    period_len(4);
    wr(OFS_RELOAD_CTRL, 8'h80);
    wait_sig(0, 20, 1, n);
    period_len(6);
    $display("test immediate done");
  endtask

  task automatic t_trigger();
    wr(OFS_RELOAD_CTRL, 8'hC1);
    trig(1'b0, 4'h0);
    wait_sig(0, 20, 0, n);
    chk("load_event", 16'(n), 16'h0000);
    trig(1'b1, 4'h5);
    wait_sig(0, 30, 1, n);
    rd(OFS_RELOAD_CTRL, 8'h41);
    trig(1'b1, 4'h0);
    wait_sig(0, 20, 0, n);
    chk("load_event", 16'(n), 16'h0000);
    $display("test trigger done");
  endtask

  task automatic t_sleep();
    @(posedge clk_sys);
    sleep_mode <= 1'b1;
    wr(OFS_MATCH_FLAGS, 8'h00);
    wr(OFS_MATCH_FLAGS, 8'h00);
    wait_sig(1, 20, 0, n);
    chk("stall", 16'(n), 16'h0000);
    for (int c = 1; c < 3; c++) begin
      wr(OFS_CLOCK_SEL, 8'(c));
      wait_sig(1, 20, 1, n);
      wr(OFS_CLOCK_SEL, 8'h00);
      wr(OFS_MATCH_FLAGS, 8'h00);
      wr(OFS_MATCH_FLAGS, 8'h00);
    end
    @(posedge clk_sys);
    sleep_mode <= 1'b0;
    wait_sig(1, 20, 1, n);
    wr(OFS_WAVE_CTRL, 8'h8C);
    period_len(10);
    wr(OFS_WAVE_CTRL, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("match_flags", match_flags, 16'h0000);
    chk("wave_out", wave_out, 16'h0000);
    $display("test sleep done");
  endtask

  // Main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    t_ctrl();
    t_immediate();
    t_trigger();
    t_sleep();
    close_out();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
